// File: logic/pds_pkg.sv
// Purpose: constants for the power down sequencer
// Assumes: 40 MHz system clock, Avalon-MM register access
// Notes: offsets are word-aligned byte addresses
package pds_pkg;
  // ==========================================
  // register map
  localparam logic [3:0] PDS_OFF_PCTRL = 4'h0;  // power_control_reg
  localparam logic [3:0] PDS_OFF_STAT = 4'h4;
  localparam logic [3:0] PDS_OFF_IRQ = 4'h8;
  localparam logic [3:0] PDS_OFF_MASK = 4'hC;
  localparam logic [7:0] PDS_SFR_ADDR = 8'h87;  // sfr location of power_control_reg
  // ==========================================
  // power_control_reg fields
  localparam int PDS_BIT_ENABLE = 1;
  localparam int PDS_BIT_START = 0;
  // status fields
  localparam int PDS_ST_SWPD = 0;
  localparam int PDS_ST_HW_POWERDOWN_N = 1;
  localparam int PDS_ST_RESET = 2;
  localparam int PDS_ST_OSCOFF = 3;
  localparam int PDS_ST_FLOAT = 4;
  localparam int PDS_ST_OWD = 5;
  localparam int PDS_ST_WDRUN = 6;
  localparam int PDS_ST_WDSTAT = 7;
  // event fields
  localparam int PDS_EV_SWPD = 0;
  localparam int PDS_EV_HW_POWERDOWN_N = 1;
  localparam int PDS_EV_WAKE = 2;
  localparam int PDS_EV_W = 3;
  // ==========================================
  // timing
  localparam int PDS_CLK_HZ = 40000000;
  localparam int PDS_MC_CLKS = 12;  // clocks per machine cycle
  localparam int PDS_RST_MC = 2;  // machine cycles of internal reset
  localparam int PDS_RC_START_US = 2000;  // rc oscillator start time
  localparam int PDS_RC_START_CLKS = (PDS_CLK_HZ / 1000000) * PDS_RC_START_US;
  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    PDS_RUN,
    PDS_HW_RESET,
    PDS_HW_DOWN,
    PDS_RC_WAIT,
    PDS_OSC_WAIT,
    PDS_SW_DOWN
  } pds_state_t;
endpackage : pds_pkg

// File: logic/pds_sequencer.sv
// Purpose: software and pin initiated power down sequencer
// Assumes: board may assert reset during hardware power down to end it
// Notes: pins sampled through two flops; machine cycle is a tick divider
`timescale 1ns/1ps
`default_nettype none
// Operation
// - enable then start, back to back only
// - both flags self-clear after being set
// - start write is last; exit by reset
// - pin low forces hardware power down; code acts on it only from run state, not in software power down
// - sample pin per machine cycle, reset
// - stop watchdog, clear its status flag
// - after reset, stop oscillators, float pins
// - stay down while pin low
// - pin high: pins leave float first
// - then enable both oscillators, rc starts
// - hold reset until main oscillator runs
// - release reset, set oscillator status flag
// - auto watchdog start when powersave pin high
// - reset pin ends hardware power down
// - powersave pin high blocks software sequence
// - flags live in power control register
module pds_sequencer #(
  parameter int RC_START_CLKS = pds_pkg::PDS_RC_START_CLKS
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic hw_powerdown_n_i,
  input wire logic powersave_allow_wdog_auto_i,
  input wire logic ext_reset_i,
  input wire logic main_osc_ok_i,
  output logic core_reset_o,
  output logic osc_enable_o,
  output logic pins_float_o,
  output logic wdog_run_o,
  output logic wdog_reset_status_o,
  output logic owd_status_o,
  output logic swpd_o,
  output logic irq_o
);
  import pds_pkg::*;

  // ==========================================
  // input synchronisers
  logic [1:0] hw_powerdown_n_sync_reg;
  logic [1:0] pse_sync_reg;
  logic [1:0] xrst_sync_reg;
  logic [1:0] osc_sync_reg;
  // two flops per pin, first stage read only by second
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      hw_powerdown_n_sync_reg <= 2'h3;
      pse_sync_reg <= 2'h3;
      xrst_sync_reg <= 2'h0;
      osc_sync_reg <= 2'h0;
    end
    else
    begin
      hw_powerdown_n_sync_reg <= {hw_powerdown_n_sync_reg[0], hw_powerdown_n_i};
      pse_sync_reg <= {pse_sync_reg[0], powersave_allow_wdog_auto_i};
      xrst_sync_reg <= {xrst_sync_reg[0], ext_reset_i};
      osc_sync_reg <= {osc_sync_reg[0], main_osc_ok_i};
    end
  end
  wire logic hw_powerdown_n_n = hw_powerdown_n_sync_reg[1];
  wire logic pse = pse_sync_reg[1];
  wire logic xrst = xrst_sync_reg[1];
  wire logic osc_ok = osc_sync_reg[1];

  // ==========================================
  // machine cycle tick
  logic [3:0] mc_cnt_reg;
  logic mc_tick;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || mc_tick)
      mc_cnt_reg <= 4'h0;
    else
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
  end
  assign mc_tick = (mc_cnt_reg == 4'(PDS_MC_CLKS - 1));

  // ==========================================
  // sequencer
  pds_state_t state_reg;
  logic [31:0] cnt_reg;
  logic en_armed_reg;
  logic pd_enable_flag_reg;
  logic pd_start_flag_reg;
  logic wr_pctrl;
  logic sw_go;
  assign wr_pctrl = avs_write_i && !avs_waitrequest_o && avs_address_i == PDS_OFF_PCTRL
                    && avs_byteenable_i[0];
  // enable armed only directly before the start write
  assign sw_go = wr_pctrl && avs_writedata_i[PDS_BIT_START] && en_armed_reg
                 && !pse && state_reg == PDS_RUN;

  // remembers that the previous bus write was to pctrl and set enable only
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      en_armed_reg <= 1'b0;
    else if (avs_write_i && !avs_waitrequest_o)
      en_armed_reg <= wr_pctrl && avs_writedata_i[PDS_BIT_ENABLE]
                      && !avs_writedata_i[PDS_BIT_START];
  end

  // flags show for one cycle then clear themselves
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pd_enable_flag_reg <= 1'b0;
      pd_start_flag_reg <= 1'b0;
    end
    else
    begin
      pd_enable_flag_reg <= wr_pctrl && avs_writedata_i[PDS_BIT_ENABLE];
      pd_start_flag_reg <= wr_pctrl && avs_writedata_i[PDS_BIT_START];
    end
  end

  logic ev_swpd;
  logic ev_hw_powerdown_n;
  logic ev_wake;
  // main power sequence
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_reg <= PDS_RUN;
      cnt_reg <= 32'h0;
    end
    else if (xrst && state_reg != PDS_RUN)
    begin
      state_reg <= PDS_RUN;
      cnt_reg <= 32'h0;
    end
    else
    begin
      unique case (state_reg)
        PDS_RUN:
        begin
          cnt_reg <= 32'h0;
          if (mc_tick && !hw_powerdown_n_n)
            state_reg <= PDS_HW_RESET;
          else if (sw_go)
            state_reg <= PDS_SW_DOWN;
        end
        PDS_HW_RESET:
        begin
          if (mc_tick)
            cnt_reg <= cnt_reg + 32'h1;
          if (mc_tick && cnt_reg == 32'(PDS_RST_MC - 1))
            state_reg <= PDS_HW_DOWN;
        end
        PDS_HW_DOWN:
        begin
          cnt_reg <= 32'h0;
          if (mc_tick && hw_powerdown_n_n)
            state_reg <= PDS_RC_WAIT;
        end
        PDS_RC_WAIT:
        begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(RC_START_CLKS - 1))
            state_reg <= PDS_OSC_WAIT;
        end
        PDS_OSC_WAIT:
        begin
          cnt_reg <= 32'h0;
          if (osc_ok)
            state_reg <= PDS_RUN;
        end
        PDS_SW_DOWN:
          cnt_reg <= 32'h0;
        default:
          state_reg <= PDS_RUN;
      endcase
    end
  end
  assign ev_swpd = sw_go;
  assign ev_hw_powerdown_n = state_reg == PDS_RUN && mc_tick && !hw_powerdown_n_n;
  assign ev_wake = state_reg == PDS_OSC_WAIT && osc_ok && !xrst;

  // ==========================================
  // outputs from flops
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      core_reset_o <= 1'b1;
      osc_enable_o <= 1'b1;
      pins_float_o <= 1'b0;
      swpd_o <= 1'b0;
    end
    else
    begin
      core_reset_o <= state_reg inside {PDS_HW_RESET, PDS_HW_DOWN, PDS_RC_WAIT, PDS_OSC_WAIT}
                      && !ev_wake;
      osc_enable_o <= !(state_reg inside {PDS_HW_DOWN, PDS_SW_DOWN});
      pins_float_o <= state_reg == PDS_HW_DOWN && !(mc_tick && hw_powerdown_n_n);
      swpd_o <= state_reg == PDS_SW_DOWN && !xrst;
    end
  end

  // watchdog control and oscillator watchdog status
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      wdog_run_o <= 1'b0;
      wdog_reset_status_o <= 1'b0;
      owd_status_o <= 1'b0;
    end
    else if (ev_hw_powerdown_n)
    begin
      wdog_run_o <= 1'b0;
      wdog_reset_status_o <= 1'b0;
      owd_status_o <= 1'b0;
    end
    else if (ev_wake)
    begin
      owd_status_o <= 1'b1;
      wdog_run_o <= pse;
    end
  end

  // ==========================================
  // interrupts and register bus
  logic [PDS_EV_W-1:0] irq_stat_reg;
  logic [PDS_EV_W-1:0] irq_mask_reg;
  logic [PDS_EV_W-1:0] ev_vec;
  assign ev_vec = {ev_wake, ev_hw_powerdown_n, ev_swpd};
  // sticky status, write one to clear, set wins
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      irq_stat_reg <= '0;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == PDS_OFF_IRQ)
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata_i[PDS_EV_W-1:0]) | ev_vec;
    else
      irq_stat_reg <= irq_stat_reg | ev_vec;
  end
  // mask register write
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      irq_mask_reg <= '0;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == PDS_OFF_MASK)
      irq_mask_reg <= avs_writedata_i[PDS_EV_W-1:0];
  end
  // level interrupt
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((irq_stat_reg | ev_vec) & irq_mask_reg);
  end

  // one wait cycle, answer on the second edge
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
  end

  // read data registered with the answer
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      avs_readdata_o <= 32'h0;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      unique case (avs_address_i)
        PDS_OFF_PCTRL:
          avs_readdata_o <= {30'h0, pd_enable_flag_reg, pd_start_flag_reg};
        PDS_OFF_STAT:
          avs_readdata_o <= {24'h0, wdog_reset_status_o, wdog_run_o, owd_status_o, pins_float_o,
                             !osc_enable_o, core_reset_o, state_reg != PDS_RUN
                             && state_reg != PDS_SW_DOWN, swpd_o};
        PDS_OFF_IRQ:
          avs_readdata_o <= {29'h0, irq_stat_reg};
        PDS_OFF_MASK:
          avs_readdata_o <= {29'h0, irq_mask_reg};
        default:
          avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // checks
  AST_SEQ_ONLY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (state_reg == PDS_RUN && $past(state_reg) == PDS_RUN) ##1 state_reg == PDS_SW_DOWN
      |-> $past(en_armed_reg) && !$past(pse))
    else $error("software power down without armed enable");
  AST_FLAG_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    pd_start_flag_reg && !wr_pctrl |=> !pd_start_flag_reg)
    else $error("start flag did not clear");
  AST_SW_STAYS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == PDS_SW_DOWN && !xrst |=> state_reg == PDS_SW_DOWN)
    else $error("left software power down without reset");
  AST_HW_ENTRY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == PDS_RUN && mc_tick && !hw_powerdown_n_n && !xrst |=> state_reg == PDS_HW_RESET ##1 core_reset_o)
    else $error("pin low did not start internal reset");
  AST_WDOG_STOP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ev_hw_powerdown_n |=> !wdog_run_o && !wdog_reset_status_o)
    else $error("watchdog not stopped on power down");
  AST_FLOAT_OSC: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    pins_float_o |-> !osc_enable_o || $past(state_reg) == PDS_HW_RESET)
    else $error("pins float while oscillator on");
  AST_HOLD_DOWN: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == PDS_HW_DOWN && !hw_powerdown_n_n && !xrst |=> state_reg == PDS_HW_DOWN)
    else $error("left hardware power down while pin low");
  AST_OWD_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == PDS_OSC_WAIT && !osc_ok |=> core_reset_o)
    else $error("reset released before oscillator ran");
  AST_WAKE_FLAG: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ev_wake |=> owd_status_o && !core_reset_o && wdog_run_o == $past(pse))
    else $error("wake did not set status or watchdog start");
  AST_RST_OVR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    xrst && state_reg == PDS_HW_DOWN |=> state_reg == PDS_RUN)
    else $error("reset pin did not end power down");
  AST_FLOAT_FIRST: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == PDS_HW_DOWN && mc_tick && hw_powerdown_n_n && !xrst |=> !pins_float_o && !osc_enable_o ##1 osc_enable_o)
    else $error("oscillators enabled before pins left float");
  AST_BUS_ANSWER: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");
endmodule : pds_sequencer
`default_nettype wire

// File: sim/pwd_board.sv
// Purpose: board logic beside the power down sequencer
// Assumes: the bench asks for power down and reset
// Notes: main oscillator runs OSC_DLY clocks after enable
`timescale 1ns/1ps
`default_nettype none
module pwd_board #(
  parameter int OSC_DLY = 40
) (
  input wire logic clk_i,
  input wire logic osc_en_i,
  input wire logic pd_req_i,
  input wire logic rst_req_i,
  input wire logic ps_i,
  output logic hw_powerdown_n_o,
  output logic ext_rst_o,
  output logic osc_ok_o,
  output logic powersave_allow_wdog_auto_o
);
  int cnt = 0;
  // ==========
  // pins follow requests; reset stays low unless asked
  assign hw_powerdown_n_o = !pd_req_i;
  assign ext_rst_o = rst_req_i;
  assign powersave_allow_wdog_auto_o = ps_i;
  // oscillator needs OSC_DLY clocks to start, stops at once
  always @(posedge clk_i)
  begin
    if (osc_en_i !== 1'b1)
      cnt <= 0;
    else if (cnt < OSC_DLY)
      cnt <= cnt + 1;
  end
  assign osc_ok_o = (cnt >= OSC_DLY);
endmodule : pwd_board
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the power down sequencer
// Assumes: rc start shortened to 20 clocks
// Notes: board model supplies pins and oscillator status
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pds_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic [3:0] adr = 4'h0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic wreq, pd_n, ps, xrst, oscok;
  logic core_rst, osc_en, flt, wd_run, wd_st, owd, swpd, irq;
  logic pd_req = 0;
  logic rst_req = 0;
  logic ps_req = 1;
  int error_cnt = 0;
  int checked = 0;
  // ==========
  // clock and hang guard
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  // ==========
  // design and board
  pds_sequencer #(.RC_START_CLKS(20)) DUT (
    .clk_sys_i(clk), .srst_i(srst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .hw_powerdown_n_i(pd_n),
    .powersave_allow_wdog_auto_i(ps), .ext_reset_i(xrst), .main_osc_ok_i(oscok),
    .core_reset_o(core_rst), .osc_enable_o(osc_en), .pins_float_o(flt),
    .wdog_run_o(wd_run), .wdog_reset_status_o(wd_st), .owd_status_o(owd),
    .swpd_o(swpd), .irq_o(irq));
  pwd_board board (
    .clk_i(clk), .osc_en_i(osc_en), .pd_req_i(pd_req), .rst_req_i(rst_req),
    .ps_i(ps_req), .hw_powerdown_n_o(pd_n), .ext_rst_o(xrst), .osc_ok_o(oscok),
    .powersave_allow_wdog_auto_o(ps));
  // ==========
  // compare, bus cycle, bounded waits
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
    end
    while (wreq !== 1'b0);
    q = rdat;
    wr <= 0;
    rd <= 0;
  endtask : bus
  function automatic logic pick(input int w);
    case (w)
      0: return core_rst;
      1: return flt;
      default: return swpd;
    endcase
  endfunction : pick
  task wait_on(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk(pick(w), v);
  endtask : wait_on
  // software sequence: first write, optional middle write, then start
  task sw_try(input logic [31:0] d0, input logic [3:0] mid, input logic ex);
    bus(1, PDS_OFF_PCTRL, d0);
    if (mid != PDS_OFF_PCTRL)
      bus(1, mid, 32'h7);
    bus(1, PDS_OFF_PCTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk(swpd, ex);
  endtask : sw_try
  // pin power down and wake, p selects automatic watchdog start
  task hw(input logic p);
    ps_req <= p;
    pd_req <= 1;
    wait_on(0, 1, 20);
    chk(owd, 0);
    chk(osc_en, 1);
    chk(flt, 0);
    chk(wd_run, 0);
    chk(wd_st, 0);
    wait_on(1, 1, 40);
    chk(osc_en, 0);
    repeat (50) @(posedge clk);
    chk(flt, 1);
    bus(0, PDS_OFF_STAT, 0);
    chk(q, 32'((1 << PDS_ST_HW_POWERDOWN_N) | (1 << PDS_ST_RESET) | (1 << PDS_ST_OSCOFF) | (1 << PDS_ST_FLOAT)));
    pd_req <= 0;
    wait_on(1, 0, 20);
    chk(osc_en, 0);
    @(posedge clk);
    chk(osc_en, 1);
    repeat (30) @(posedge clk);
    chk(core_rst, 1);
    wait_on(0, 0, 100);
    chk(owd, 1);
    chk(wd_run, p);
  endtask : hw
  task results;
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // ==========
  // test sequence
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 0;
    bus(0, PDS_OFF_PCTRL, 0);
    chk(q, 32'h0);
    bus(1, PDS_OFF_MASK, 32'h7);
    bus(0, PDS_OFF_MASK, 0);
    chk(q, 32'h7);
    bus(1, 4'h2, 32'hFF);
    bus(0, 4'h2, 0);
    chk(q, 32'h0);
    sw_try(32'h2, PDS_OFF_PCTRL, 0);
    ps_req <= 0;
    sw_try(32'h1, PDS_OFF_PCTRL, 0);
    sw_try(32'h3, PDS_OFF_PCTRL, 0);
    sw_try(32'h2, PDS_OFF_MASK, 0);
    // armed enable survives a read, then start enters power down
    bus(1, PDS_OFF_PCTRL, 32'h2);
    repeat (2) @(posedge clk);
    bus(0, PDS_OFF_PCTRL, 0);
    chk(q, 32'h0);
    bus(1, PDS_OFF_PCTRL, 32'h1);
    wait_on(2, 1, 5);
    repeat (50) @(posedge clk);
    chk(swpd, 1);
    bus(0, PDS_OFF_PCTRL, 0);
    chk(q, 32'h0);
    bus(0, PDS_OFF_IRQ, 0);
    chk(q, 32'h1);
    chk(irq, 1);
    bus(1, PDS_OFF_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    bus(1, PDS_OFF_IRQ, 32'h1);
    bus(1, PDS_OFF_MASK, 32'h7);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    rst_req <= 1;
    wait_on(2, 0, 10);
    rst_req <= 0;
    hw(1);
    bus(0, PDS_OFF_IRQ, 0);
    chk(q, 32'h6);
    hw(0);
    // reset pin during pin power down returns to normal reset
    pd_req <= 1;
    wait_on(1, 1, 60);
    rst_req <= 1;
    repeat (6) @(posedge clk);
    chk(flt, 0);
    chk(osc_en, 1);
    rst_req <= 0;
    pd_req <= 0;
    wait_on(0, 0, 200);
    results();
  end
endmodule : testbench
`default_nettype wire
